// *** src/asc_chain.sv ***
`timescale 1ns/100ps
`include "asc_cfg.svh"

// Function
// - Tap output captured in flop, same clock
// - Cascade output also captured in own flop
// - Segment tap length equals address plus one
// - Static 40 stages: cascade, last address 0111
// - Alternative 39 stages 0110 plus final flop
// - Segments load 16-bit initial value, default zero
// - Segment ports: data, clock, enable, address, outputs
// - Lengths 16, 32, 64, 128, 256 from segments
// - Tree joins 2, 4, 8, 16 segments
// - Widths 2:1 to 16:1, one level each
// - Selection tree purely combinational, no registers
// - Enabled edge loads input, shifts bits up
// - Tap follows address without clock or enable
// - Cascade output always last stage after shift
// - Clock edge and enable polarity selectable
module asc_chain
   import asc_pkg::*;
#(
   parameter logic [`ASC_NSEG*`ASC_SEG_LEN-1:0] INIT_ALL =
      {`ASC_NSEG{`ASC_INIT_DEFAULT}},
   parameter bit CLK_FALL = 1'b0,
   parameter bit CE_LOW   = 1'b0
) (
   input  wire logic                   clk,       // Chain clock
   input  wire logic                   rst,       // Async reset, high
   input  wire logic                   in_valid,  // Serial bit offered
   input  wire logic                   in_data,   // Serial bit
   output logic                        in_ready,  // Chain can shift
   input  wire logic [`ASC_ADDR_W-1:0] tap_addr,  // Tap address
   input  wire asc_pkg::asc_len_t      len_sel,   // Configured length
   input  wire asc_pkg::asc_mode_t     mode_sel,  // Dynamic or static
   output logic                        out_valid, // Buffered word ready
   output logic                        out_tap,   // Registered tap
   output logic                        out_casc,  // Registered cascade
   input  wire logic                   out_ready  // Receiver takes word
);
   import asc_pkg::*;

   logic                  seg_tap  [`ASC_NSEG];
   logic                  seg_casc [`ASC_NSEG];
   logic                  node     [`ASC_TREE_NODES];
   logic [`ASC_SEG_AW-1:0] seg_addr;
   logic [`ASC_SEL_W-1:0]  tree_sel;
   logic [`ASC_SEL_W-1:0]  len_mask;
   logic [`ASC_SEL_W-1:0]  last_seg;
   logic                   chain_casc;
   logic                   fire;
   logic                   pop;
   asc_word_t              new_word;

   logic                   pend_r;
   logic                   pend_nxt;
   logic [1:0]             cnt_r;
   logic [1:0]             cnt_nxt;
   asc_word_t              ent_r   [`ASC_BUF_DEPTH];
   asc_word_t              ent_nxt [`ASC_BUF_DEPTH];
   logic                   in_ready_r;
   logic                   in_ready_nxt;
   logic                   out_valid_r;
   logic                   out_valid_nxt;

   asc_seg_if sif [`ASC_NSEG] ();

   // Length decode: which segments are live and which address bits count
   always_comb begin
      len_mask = `ASC_MASK_L16;
      last_seg = `ASC_LAST_L16;
      unique case (len_sel)
         ASC_L16: begin
            len_mask = `ASC_MASK_L16;
            last_seg = `ASC_LAST_L16;
         end
         ASC_L32: begin
            len_mask = `ASC_MASK_L32;
            last_seg = `ASC_LAST_L32;
         end
         ASC_L64: begin
            len_mask = `ASC_MASK_L64;
            last_seg = `ASC_LAST_L64;
         end
         ASC_L128: begin
            len_mask = `ASC_MASK_L128;
            last_seg = `ASC_LAST_L128;
         end
         ASC_L256: begin
            len_mask = `ASC_MASK_L256;
            last_seg = `ASC_LAST_L256;
         end
         default: begin
            len_mask = `ASC_MASK_L16;
            last_seg = `ASC_LAST_L16;
         end
      endcase
   end

   // Address steering for dynamic and fixed-length modes
   always_comb begin
      seg_addr = tap_addr[`ASC_SEG_AW-1:0];
      tree_sel = tap_addr[`ASC_ADDR_W-1:`ASC_SEG_AW] & len_mask;
      unique case (mode_sel)
         ASC_DYN: begin
            seg_addr = tap_addr[`ASC_SEG_AW-1:0];
            tree_sel = tap_addr[`ASC_ADDR_W-1:`ASC_SEG_AW] & len_mask;
         end
         ASC_ST40: begin
            seg_addr = `ASC_ST40_ADDR;
            tree_sel = `ASC_ST_SEG;
         end
         ASC_ST39F: begin
            seg_addr = `ASC_ST39_ADDR;
            tree_sel = `ASC_ST_SEG;
         end
         default: begin
            seg_addr = tap_addr[`ASC_SEG_AW-1:0];
            tree_sel = tap_addr[`ASC_ADDR_W-1:`ASC_SEG_AW] & len_mask;
         end
      endcase
   end

   // Segments in series, each after the first fed by the previous cascade output
   genvar g;
   generate
      for (g = 0; g < `ASC_NSEG; g++) begin : g_seg
         if (g == 0) begin : g_head
            assign sif[g].din = in_data;
         end else begin : g_link
            assign sif[g].din = sif[g-1].casc;
         end
         assign sif[g].ce   = fire ^ CE_LOW;
         assign sif[g].addr = seg_addr;
         assign seg_tap[g]  = sif[g].tap;
         assign seg_casc[g] = sif[g].casc;
         assign node[`ASC_NSEG+g] = seg_tap[g];

         asc_segment #(
            .INIT     (INIT_ALL[g*`ASC_SEG_LEN +: `ASC_SEG_LEN]),
            .CLK_FALL (CLK_FALL),
            .CE_LOW   (CE_LOW)
         ) u_seg (
            .clk (clk),
            .rst (rst),
            .sif (sif[g])
         );
      end
   endgenerate

   // Heap-ordered 2:1 tree; depth d node uses select bit 3-d.
   // Levels join 2, 4, 8 and 16 segments with no register inside.
   genvar n;
   generate
      for (n = 1; n < `ASC_NSEG; n++) begin : g_tree
         localparam int DEPTH = $clog2(n + 1) - 1;
         assign node[n] = tree_sel[`ASC_SEL_W-1-DEPTH] ?
                          node[2*n+1] : node[2*n];
      end
   endgenerate
   assign node[0] = 1'b0;

   // Static chains end at the fixed segment
   assign chain_casc = (mode_sel == ASC_DYN) ? seg_casc[last_seg]
                                             : seg_casc[`ASC_ST_SEG];

   assign new_word.tap  = node[1];
   assign new_word.casc = chain_casc;

   // Output buffer. A shift is captured one cycle later, when the
   // pending bit pushes the new tap and cascade values into it.
   always_comb begin
      fire          = in_valid & in_ready_r;
      pop           = out_valid_r & out_ready;
      pend_nxt      = fire;
      cnt_nxt       = cnt_r;
      ent_nxt[0]    = ent_r[0];
      ent_nxt[1]    = ent_r[1];
      if (pop) begin
         ent_nxt[0] = ent_r[1];
         cnt_nxt    = cnt_r - 2'h1;
      end
      if (pend_r) begin
         if (cnt_nxt == `ASC_CNT_EMPTY) begin
            ent_nxt[0] = new_word;
         end else begin
            ent_nxt[1] = new_word;
         end
         cnt_nxt = cnt_nxt + 2'h1;
      end
      // Count a shift in flight so a stalled receiver loses nothing
      in_ready_nxt  = (cnt_nxt + {1'b0, fire}) <= `ASC_CNT_ONE;
      out_valid_nxt = cnt_nxt != `ASC_CNT_EMPTY;
   end

   // The buffer entries are the output flip-flops on the chain clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_r      <= 1'b0;
         cnt_r       <= `ASC_CNT_EMPTY;
         ent_r[0]    <= '0;
         ent_r[1]    <= '0;
         in_ready_r  <= 1'b1;
         out_valid_r <= 1'b0;
      end else begin
         pend_r      <= pend_nxt;
         cnt_r       <= cnt_nxt;
         ent_r[0]    <= ent_nxt[0];
         ent_r[1]    <= ent_nxt[1];
         in_ready_r  <= in_ready_nxt;
         out_valid_r <= out_valid_nxt;
      end
   end

   assign in_ready  = in_ready_r;
   assign out_valid = out_valid_r;
   assign out_tap   = ent_r[0].tap;
   assign out_casc  = ent_r[0].casc;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_shift;
      in_valid && in_ready_r;
   endsequence

   sequence s_capture;
      pend_r && cnt_r == `ASC_CNT_EMPTY && !pop;
   endsequence

   chk_shift_capture: assert property (
      s_shift |=> s_capture or (pend_r && cnt_r != `ASC_CNT_EMPTY)
                  or (pend_r && pop))
      else $error("shift not followed by capture");

   chk_tap_captured: assert property (
      s_capture |=> out_tap == $past(node[1]) && out_valid)
      else $error("tap value not registered into buffer");

   chk_casc_captured: assert property (
      s_capture |=> out_casc == $past(chain_casc))
      else $error("cascade value not registered into buffer");

   chk_static_forty: assert property (
      mode_sel == ASC_ST40 |-> seg_addr == `ASC_ST40_ADDR
                               && node[1] == seg_tap[`ASC_ST_SEG])
      else $error("static forty tap not fixed");

   chk_static_flop: assert property (
      mode_sel == ASC_ST39F |-> seg_addr == `ASC_ST39_ADDR
                                && node[1] == seg_tap[`ASC_ST_SEG])
      else $error("static thirty-nine tap not fixed");

   chk_len_sixteen: assert property (
      mode_sel == ASC_DYN && len_sel == ASC_L16
      |-> node[1] == seg_tap[0] && chain_casc == seg_casc[0])
      else $error("sixteen-stage chain uses other segments");

   chk_tree_select: assert property (
      mode_sel == ASC_DYN && len_sel == ASC_L256
      |-> node[1] == seg_tap[tap_addr[`ASC_ADDR_W-1:`ASC_SEG_AW]])
      else $error("tree selected wrong segment");

   chk_addr_follow: assert property (
      mode_sel == ASC_DYN && !fire && !pend_r && $changed(tap_addr)
      |-> seg_addr == tap_addr[`ASC_SEG_AW-1:0])
      else $error("tap address not applied at once");

   chk_buf_no_over: assert property (
      cnt_r == `ASC_CNT_FULL |-> !in_ready_r && !pend_r)
      else $error("buffer may overflow");

   chk_stall_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_tap)
                                  && $stable(out_casc))
      else $error("stalled word changed");

   // Room check counts the word still waiting to be captured
   chk_ready_room: assert property (
      in_ready_r |-> (cnt_r + {1'b0, pend_r}) <= `ASC_CNT_ONE)
      else $error("ready raised without buffer room");

   chk_valid_count: assert property (
      out_valid_r == (cnt_r != `ASC_CNT_EMPTY))
      else $error("valid flag disagrees with buffer count");

   chk_second_word: assert property (
      pop && cnt_r == `ASC_CNT_FULL |=> out_valid
                                        && out_tap == $past(ent_r[1].tap))
      else $error("second buffered word not advanced");

   chk_capture_pop: assert property (
      pend_r && pop && cnt_r == `ASC_CNT_ONE
      |=> out_valid && out_tap == $past(node[1]))
      else $error("tap lost when capture met a pop");

   chk_casc_link: assert property (
      (s_shift ##1 (seg_addr == '0)) |-> seg_tap[1] == $past(seg_casc[0]))
      else $error("segment not fed by previous cascade output");

   chk_idle_no_move: assert property (
      !fire |=> $stable(seg_casc[0]))
      else $error("chain moved without an accepted shift");
endmodule // asc_chain

// *** src/asc_cfg.svh ***
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// Segment geometry
`define ASC_SEG_LEN       16
`define ASC_SEG_AW        4
`define ASC_SEG_LAST      15
`define ASC_NSEG          16
`define ASC_SEL_W         4
`define ASC_ADDR_W        8
`define ASC_TREE_NODES    32
`define ASC_INIT_DEFAULT  16'h0000

// Fixed taps for the 40-stage and 39-stage static chains
`define ASC_ST_SEG        4'h2
`define ASC_ST40_ADDR     4'h7
`define ASC_ST39_ADDR     4'h6

// Upper-address masks per configured length
`define ASC_MASK_L16      4'h0
`define ASC_MASK_L32      4'h1
`define ASC_MASK_L64      4'h3
`define ASC_MASK_L128     4'h7
`define ASC_MASK_L256     4'hf

// Index of the last segment per configured length
`define ASC_LAST_L16      4'h0
`define ASC_LAST_L32      4'h1
`define ASC_LAST_L64      4'h3
`define ASC_LAST_L128     4'h7
`define ASC_LAST_L256     4'hf

// Output buffer
`define ASC_BUF_DEPTH     2
`define ASC_CNT_EMPTY     2'h0
`define ASC_CNT_ONE       2'h1
`define ASC_CNT_FULL      2'h2

`endif

// *** src/asc_pkg.sv ***
package asc_pkg;

   typedef enum logic [2:0] {
      ASC_L16,
      ASC_L32,
      ASC_L64,
      ASC_L128,
      ASC_L256
   } asc_len_t;

   typedef enum logic [1:0] {
      ASC_DYN,
      ASC_ST40,
      ASC_ST39F
   } asc_mode_t;

   typedef struct packed {
      logic tap;
      logic casc;
   } asc_word_t;

endpackage

// *** src/asc_seg_if.sv ***
`timescale 1ns/100ps
`include "asc_cfg.svh"

interface asc_seg_if;
   logic                   din;
   logic                   ce;
   logic [`ASC_SEG_AW-1:0] addr;
   logic                   tap;
   logic                   casc;

   modport seg   (input din, ce, addr, output tap, casc);
   modport chain (output din, ce, addr, input tap, casc);
endinterface

// *** src/asc_segment.sv ***
`timescale 1ns/100ps
`include "asc_cfg.svh"

module asc_segment #(
   parameter logic [`ASC_SEG_LEN-1:0] INIT     = `ASC_INIT_DEFAULT,
   parameter bit                      CLK_FALL = 1'b0,
   parameter bit                      CE_LOW   = 1'b0
) (
   input  wire logic clk,      // Shared chain clock
   input  wire logic rst,      // Loads the initial contents
   asc_seg_if.seg    sif       // Data, enable, tap address, outputs
);
   logic                    clk_eff;
   logic                    shift_en;
   logic [`ASC_SEG_LEN-1:0] stg_r;
   logic [`ASC_SEG_LEN-1:0] stg_nxt;

   // Static inversion only; never toggled at run time
   assign clk_eff  = clk ^ CLK_FALL;
   assign shift_en = sif.ce ^ CE_LOW;

   always_comb begin
      stg_nxt = stg_r;
      if (shift_en) begin
         stg_nxt = {stg_r[`ASC_SEG_LAST-1:0], sif.din};
      end
   end

   always_ff @(posedge clk_eff or posedge rst) begin
      if (rst) begin
         stg_r <= INIT;
      end else begin
         stg_r <= stg_nxt;
      end
   end

   // Address 0 reads stage 0, so length is address plus one
   assign sif.tap  = stg_r[sif.addr];
   assign sif.casc = stg_r[`ASC_SEG_LAST];

   chk_seg_shift_in: assert property (@(posedge clk_eff) disable iff (rst)
      (sif.ce ^ CE_LOW) |=> stg_r[0] == $past(sif.din))
      else $error("segment did not load serial input");

   chk_seg_hold_off: assert property (@(posedge clk_eff) disable iff (rst)
      !(sif.ce ^ CE_LOW) |=> $stable(stg_r))
      else $error("segment moved while disabled");

   chk_casc_last_stage: assert property (@(posedge clk_eff) disable iff (rst)
      (sif.ce ^ CE_LOW) |=> sif.casc == $past(stg_r[`ASC_SEG_LAST-1]))
      else $error("cascade output is not the last stage");

   chk_tap_len_one: assert property (@(posedge clk_eff) disable iff (rst)
      ((sif.ce ^ CE_LOW) ##1 (sif.addr == 4'h0)) |-> sif.tap == $past(sif.din))
      else $error("address zero is not a one-stage tap");
endmodule // asc_segment

// *** test/asc_sink_model.sv ***
`timescale 1ns/100ps

module asc_sink_model (
   input  wire logic clk,       // Chain clock
   input  wire logic rst,       // Async reset, high
   input  wire logic stall,     // Holds the receiver off
   output logic      out_ready  // Receiver takes the head word
);
   // Random back-pressure keeps both buffer entries in play
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall && (2'($urandom) != 2'h0);
      end
   end
endmodule // asc_sink_model

// *** test/addressable_shift_chain_tb_top.sv ***
`timescale 1ns/100ps

module addressable_shift_chain_tb_top;
   import asc_pkg::*;

   logic         clk, rst, in_valid, in_data, in_ready, stall;
   logic         out_valid, out_tap, out_casc, out_ready;
   logic [7:0]   tap_addr;
   asc_len_t     len_sel;
   asc_mode_t    mode_sel;
   logic [255:0] ref_q;
   asc_word_t    exp_q[$];
   int           n_mismatch, samples_checked, seed;

   always #2.5 clk = ~clk;

   asc_chain dut (
      .clk(clk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
      .in_ready(in_ready), .tap_addr(tap_addr), .len_sel(len_sel),
      .mode_sel(mode_sel), .out_valid(out_valid), .out_tap(out_tap),
      .out_casc(out_casc), .out_ready(out_ready)
   );

   asc_sink_model sink (
      .clk(clk), .rst(rst), .stall(stall), .out_ready(out_ready)
   );

   task check(input string what, input logic [1:0] seen,
              input logic [1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task close_out;
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task give_up(input string what);
      n_mismatch++;
      $display("Error %s expected done seen timeout", what);
      close_out();
   endtask

   // Stage 0 holds the newest bit; stage index is segment*16 + address
   function automatic asc_word_t expect_word(input logic [7:0] a);
      logic [3:0] m;
      m = 4'((1 << len_sel) - 1);
      if (mode_sel == ASC_ST40) begin
         return '{tap: ref_q[39], casc: ref_q[47]};
      end else if (mode_sel == ASC_ST39F) begin
         return '{tap: ref_q[38], casc: ref_q[47]};
      end
      return '{tap: ref_q[{a[7:4] & m, a[3:0]}],
               casc: ref_q[{m, 4'hf}]};
   endfunction

   // Pops are judged in shift order
   always @(posedge clk) begin
      if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare word", 2'b01, 2'b00);
         end else begin
            check("tap casc", {out_tap, out_casc}, exp_q.pop_front());
         end
      end
   end

   // Address is held through the capture cycle after the shift
   task shift(input logic b, input logic [7:0] a);
      int i;
      in_valid <= 1'b1;
      in_data  <= b;
      tap_addr <= a;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (in_ready === 1'b1) break;
      end
      if (i == 64) give_up("shift accept");
      // Ready can stay high after a take, so drop valid at once
      in_valid <= 1'b0;
      ref_q = {ref_q[254:0], b};
      exp_q.push_back(expect_word(a));
      @(posedge clk);
   endtask

   task run(input int n);
      repeat (n) shift(1'($urandom), 8'($urandom));
   endtask

   task drain;
      int i;
      for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk);
      if (exp_q.size() > 0) give_up("drain");
   endtask

   task do_reset(input asc_len_t l, input asc_mode_t md);
      drain();
      rst      <= 1'b1;
      len_sel  <= l;
      mode_sel <= md;
      repeat (6) @(posedge clk);
      check("reset flags", {in_ready, out_valid}, 2'b10);
      check("reset word", {out_tap, out_casc}, 2'b00);
      rst   <= 1'b0;
      ref_q = '0;
      @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      in_valid = 1'b0;
      in_data = 1'b0;
      tap_addr = 8'h00;
      len_sel = ASC_L16;
      mode_sel = ASC_DYN;
      stall = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      seed = $urandom(69799);
      do_reset(ASC_L16, ASC_DYN);
      // Receiver stalls: two words fill the buffer, then input refuses
      stall <= 1'b1;
      shift(1'b1, 8'h00);
      shift(1'b0, 8'h0f);
      repeat (3) @(posedge clk);
      check("full buffer", {in_ready, out_valid}, 2'b01);
      stall <= 1'b0;
      for (int l = 0; l < 5; l++) begin
         do_reset(asc_len_t'(l), ASC_DYN);
         run((16 << l) + 24);
         shift(1'b1, 8'hff);
         shift(1'b0, 8'h10);
      end
      do_reset(ASC_L64, ASC_DYN);
      run(40);
      repeat (3) shift(1'($urandom), 8'h27);
      do_reset(ASC_L256, ASC_ST40);
      run(60);
      do_reset(ASC_L256, ASC_ST39F);
      run(60);
      drain();
      close_out();
   end
endmodule // addressable_shift_chain_tb_top
